// *** hdl/rx_checksum_counter_irq_mask.sv ***
// receive checksum counter interrupt mask and status with wishbone access
//
// What this block does
// - one 32-bit mask register sits at byte offset 0x200.
// - a mask bit at one stops its counter's half and full interrupts.
// - bits 29 and 28 mask the bad and good ICMP byte counters, both r/w.
// - bits 27 and 26 mask the bad and good TCP byte counters.
// - bits 25 and 24 mask the bad and good UDP byte counters.
// - bits 23..21 mask the v6 no-payload, header-bad and good byte counters.
// - bits 20..16 mask the v4 no-csum, fragment, no-payload, bad, good bytes.
// - bits 13 and 12 mask the bad and good ICMP frame counters.
// - bits 11 and 10 mask the bad and good TCP frame counters.
// - bits 9 and 8 mask the bad and good UDP frame counters.
// - bits 7..0 mask the v6 and v4 frame counters in the byte-counter order.
// - a half or full crossing always sets its status bit; the mask only gates.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module rx_checksum_counter_irq_mask (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [31:0] counter_half,
  input  wire logic [31:0] counter_max,
  output logic             irq
);
  import rx_csum_pkg::*;
  `include "rx_csum_map.svh"

  // -----------------------------------------------------------------
  // bus front end
  // -----------------------------------------------------------------
  wb_req_t       req;
  logic [31:0]   rdata;
  logic          wr_stb;
  logic [31:0]   mask;
  logic [31:0]   status;
  counter_bits_t mask_f;
  counter_bits_t status_f;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                 adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

  wb_word_slave u_bus (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .req     (req),
    .rdata   (rdata),
    .ack     (wb_ack_o),
    .dat_o   (wb_dat_o),
    .wr_stb  (wr_stb)
  );

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  // one register per 32-bit word; address bits 1:0 are ignored
  function automatic logic word_hit(input logic [11:0] adr,
                                    input logic [11:0] off);
    word_hit = adr[11:2] == off[11:2];
  endfunction

  wire        hit_mask   = word_hit(req.adr, `RCM_MASK_OFF);
  wire        hit_status = word_hit(req.adr, `RCM_STATUS_OFF);
  wire [31:0] lanes      = lane_mask(req.sel);
  wire        wr_mask    = wr_stb & hit_mask;
  wire        wr_status  = wr_stb & hit_status;

  // unmapped offsets read zero and drop writes
  assign rdata = hit_mask   ? mask   :
                 hit_status ? status : 32'h0000_0000;

  // -----------------------------------------------------------------
  // mask register
  // -----------------------------------------------------------------
  wire [31:0] next_mask =
    ((mask & ~lanes) | (req.dat & lanes)) & `RCM_VALID;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask <= `RCM_MASK_RST;
    end else if (wr_mask) begin
      mask <= next_mask;
    end
  end

  assign mask_f = counter_bits_t'(mask);

  // -----------------------------------------------------------------
  // status register and interrupt
  // -----------------------------------------------------------------
  wire [31:0] crossing = counter_half | counter_max;
  wire [31:0] clr_vec  = wr_status ? (req.dat & lanes) : 32'h0000_0000;

  sticky_w1c u_status (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set     (crossing),
    .clr     (clr_vec),
    .q       (status)
  );

  assign status_f = counter_bits_t'(status);

  // status always records the crossing; only the output is gated
  wire [31:0] pending = status & ~mask;
  assign irq = |pending;

  // -----------------------------------------------------------------
  // checks: bus handshake
  // -----------------------------------------------------------------
  sequence bus_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence full_mask_wr_s;
    wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && hit_mask
      && wb_sel_i == 4'hf;
  endsequence

  ack_follows_req_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    bus_req_s |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not given one cycle after the request");

  read_data_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    bus_req_s and !wb_we_i and hit_mask |=> wb_dat_o == $past(mask))
    else $error("mask read data wrong");

  // -----------------------------------------------------------------
  // checks: mask register
  // -----------------------------------------------------------------
  property field_load(logic f, int b);
    @(posedge clk_sys) disable iff (!rst_n)
    full_mask_wr_s |=> f == $past(wb_dat_i[b]);
  endproperty

  mask_write_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    full_mask_wr_s |=> mask == ($past(wb_dat_i) & `RCM_VALID))
    else $error("mask write not stored");

  mask_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !wr_mask |=> $stable(mask))
    else $error("mask changed without a write");

  reserved_zero_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    mask_f.rsvd_hi == 2'b00 && mask_f.rsvd_mid == 2'b00
      && status_f.rsvd_hi == 2'b00 && status_f.rsvd_mid == 2'b00)
    else $error("reserved bits not zero");

  icmp_byte_a: assert property (
    field_load(mask_f.icmp_bad_byte_count, `ICMP_BAD_BYTE_BIT))
    else $error("icmp byte mask field misplaced");

  tcp_byte_a: assert property (
    field_load(mask_f.tcp_good_byte_count, `TCP_GOOD_BYTE_BIT))
    else $error("tcp byte mask field misplaced");

  udp_byte_a: assert property (
    field_load(mask_f.udp_bad_byte_count, `UDP_BAD_BYTE_BIT))
    else $error("udp byte mask field misplaced");

  v6_byte_a: assert property (
    field_load(mask_f.v6_header_bad_byte_count, `V6_HEADER_BAD_BYTE_BIT))
    else $error("v6 byte mask field misplaced");

  v4_byte_a: assert property (
    field_load(mask_f.v4_fragment_byte_count, `V4_FRAGMENT_BYTE_BIT))
    else $error("v4 byte mask field misplaced");

  icmp_frame_a: assert property (
    field_load(mask_f.icmp_good_frame_count, `ICMP_GOOD_FRAME_BIT))
    else $error("icmp frame mask field misplaced");

  tcp_frame_a: assert property (
    field_load(mask_f.tcp_bad_frame_count, `TCP_BAD_FRAME_BIT))
    else $error("tcp frame mask field misplaced");

  udp_frame_a: assert property (
    field_load(mask_f.udp_good_frame_count, `UDP_GOOD_FRAME_BIT))
    else $error("udp frame mask field misplaced");

  v_frame_a: assert property (
    field_load(mask_f.v4_good_frame_count, `V4_GOOD_FRAME_BIT))
    else $error("v4 frame mask field misplaced");

  v6_frame_a: assert property (
    field_load(mask_f.v6_nopayload_frame_count, `V6_NOPAYLOAD_FRAME_BIT))
    else $error("v6 frame mask field misplaced");

  icmp_good_byte_a: assert property (
    field_load(mask_f.icmp_good_byte_count, `ICMP_GOOD_BYTE_BIT))
    else $error("icmp good byte mask field misplaced");

  tcp_bad_byte_a: assert property (
    field_load(mask_f.tcp_bad_byte_count, `TCP_BAD_BYTE_BIT))
    else $error("tcp bad byte mask field misplaced");

  udp_good_byte_a: assert property (
    field_load(mask_f.udp_good_byte_count, `UDP_GOOD_BYTE_BIT))
    else $error("udp good byte mask field misplaced");

  v6_nopay_byte_a: assert property (
    field_load(mask_f.v6_nopayload_byte_count, `V6_NOPAYLOAD_BYTE_BIT))
    else $error("v6 no-payload byte mask field misplaced");

  v6_good_byte_a: assert property (
    field_load(mask_f.v6_good_byte_count, `V6_GOOD_BYTE_BIT))
    else $error("v6 good byte mask field misplaced");

  v4_nocsum_byte_a: assert property (
    field_load(mask_f.v4_udp_nocsum_byte_count, `V4_UDP_NOCSUM_BYTE_BIT))
    else $error("v4 no-checksum byte mask field misplaced");

  v4_nopay_byte_a: assert property (
    field_load(mask_f.v4_nopayload_byte_count, `V4_NOPAYLOAD_BYTE_BIT))
    else $error("v4 no-payload byte mask field misplaced");

  v4_hdr_byte_a: assert property (
    field_load(mask_f.v4_header_bad_byte_count, `V4_HEADER_BAD_BYTE_BIT))
    else $error("v4 header-bad byte mask field misplaced");

  v4_good_byte_a: assert property (
    field_load(mask_f.v4_good_byte_count, `V4_GOOD_BYTE_BIT))
    else $error("v4 good byte mask field misplaced");

  icmp_bad_frame_a: assert property (
    field_load(mask_f.icmp_bad_frame_count, `ICMP_BAD_FRAME_BIT))
    else $error("icmp bad frame mask field misplaced");

  tcp_good_frame_a: assert property (
    field_load(mask_f.tcp_good_frame_count, `TCP_GOOD_FRAME_BIT))
    else $error("tcp good frame mask field misplaced");

  udp_bad_frame_a: assert property (
    field_load(mask_f.udp_bad_frame_count, `UDP_BAD_FRAME_BIT))
    else $error("udp bad frame mask field misplaced");

  v6_hdr_frame_a: assert property (
    field_load(mask_f.v6_header_bad_frame_count, `V6_HEADER_BAD_FRAME_BIT))
    else $error("v6 header-bad frame mask field misplaced");

  v6_good_frame_a: assert property (
    field_load(mask_f.v6_good_frame_count, `V6_GOOD_FRAME_BIT))
    else $error("v6 good frame mask field misplaced");

  v4_nocsum_frame_a: assert property (
    field_load(mask_f.v4_udp_nocsum_frame_count, `V4_UDP_NOCSUM_FRAME_BIT))
    else $error("v4 no-checksum frame mask field misplaced");

  v4_frag_frame_a: assert property (
    field_load(mask_f.v4_fragment_frame_count, `V4_FRAGMENT_FRAME_BIT))
    else $error("v4 fragment frame mask field misplaced");

  v4_nopay_frame_a: assert property (
    field_load(mask_f.v4_nopayload_frame_count, `V4_NOPAYLOAD_FRAME_BIT))
    else $error("v4 no-payload frame mask field misplaced");

  v4_hdr_frame_a: assert property (
    field_load(mask_f.v4_header_bad_frame_count, `V4_HEADER_BAD_FRAME_BIT))
    else $error("v4 header-bad frame mask field misplaced");

  // -----------------------------------------------------------------
  // checks: status and interrupt
  // -----------------------------------------------------------------
  status_set_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (crossing & `RCM_VALID) != 32'h0000_0000
      |=> (status & $past(crossing & `RCM_VALID))
        == $past(crossing & `RCM_VALID))
    else $error("crossing did not set status");

  set_beats_clear_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    wr_status && (crossing & req.dat & lanes & `RCM_VALID) != 0
      |=> (status & $past(crossing & `RCM_VALID))
        == $past(crossing & `RCM_VALID))
    else $error("clear won over a new crossing");

  w1c_clear_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    wr_status && crossing == 32'h0000_0000
      |=> (status & $past(req.dat & lanes)) == 32'h0000_0000)
    else $error("write one did not clear status");

  masked_quiet_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (status & ~mask) == 32'h0000_0000 && !wr_mask
      && crossing == 32'h0000_0000 |=> !irq)
    else $error("masked crossing raised the interrupt");

  unmasked_irq_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (crossing & ~mask & `RCM_VALID) != 32'h0000_0000 && !wr_mask
      |=> irq)
    else $error("unmasked crossing gave no interrupt");

endmodule // rx_checksum_counter_irq_mask

// *** hdl/rx_csum_map.svh ***
// register offsets, field positions and reset values of the mask block
`ifndef RX_CSUM_MAP_SVH
`define RX_CSUM_MAP_SVH

// -----------------------------------------------------------------
// register offsets (byte addresses)
// -----------------------------------------------------------------
`define RCM_MASK_OFF    12'h200
`define RCM_STATUS_OFF  12'h208
`define RCM_ADR_W       12

// -----------------------------------------------------------------
// reset values and implemented bits
// -----------------------------------------------------------------
`define RCM_MASK_RST    32'h0000_0000
`define RCM_STATUS_RST  32'h0000_0000
`define RCM_VALID       32'h3fff_3fff

// -----------------------------------------------------------------
// octet counter field positions
// -----------------------------------------------------------------
`define ICMP_BAD_BYTE_BIT        29
`define ICMP_GOOD_BYTE_BIT       28
`define TCP_BAD_BYTE_BIT         27
`define TCP_GOOD_BYTE_BIT        26
`define UDP_BAD_BYTE_BIT         25
`define UDP_GOOD_BYTE_BIT        24
`define V6_NOPAYLOAD_BYTE_BIT    23
`define V6_HEADER_BAD_BYTE_BIT   22
`define V6_GOOD_BYTE_BIT         21
`define V4_UDP_NOCSUM_BYTE_BIT   20
`define V4_FRAGMENT_BYTE_BIT     19
`define V4_NOPAYLOAD_BYTE_BIT    18
`define V4_HEADER_BAD_BYTE_BIT   17
`define V4_GOOD_BYTE_BIT         16

// -----------------------------------------------------------------
// frame counter field positions
// -----------------------------------------------------------------
`define ICMP_BAD_FRAME_BIT       13
`define ICMP_GOOD_FRAME_BIT      12
`define TCP_BAD_FRAME_BIT        11
`define TCP_GOOD_FRAME_BIT       10
`define UDP_BAD_FRAME_BIT        9
`define UDP_GOOD_FRAME_BIT       8
`define V6_NOPAYLOAD_FRAME_BIT   7
`define V6_HEADER_BAD_FRAME_BIT  6
`define V6_GOOD_FRAME_BIT        5
`define V4_UDP_NOCSUM_FRAME_BIT  4
`define V4_FRAGMENT_FRAME_BIT    3
`define V4_NOPAYLOAD_FRAME_BIT   2
`define V4_HEADER_BAD_FRAME_BIT  1
`define V4_GOOD_FRAME_BIT        0

`endif

// *** hdl/rx_csum_pkg.sv ***
// types shared by the receive checksum counter mask block
package rx_csum_pkg;

  // -----------------------------------------------------------------
  // wishbone request as seen by the slave
  // -----------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  // -----------------------------------------------------------------
  // one bit per counter, same layout for mask and status
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic       icmp_bad_byte_count;
    logic       icmp_good_byte_count;
    logic       tcp_bad_byte_count;
    logic       tcp_good_byte_count;
    logic       udp_bad_byte_count;
    logic       udp_good_byte_count;
    logic       v6_nopayload_byte_count;
    logic       v6_header_bad_byte_count;
    logic       v6_good_byte_count;
    logic       v4_udp_nocsum_byte_count;
    logic       v4_fragment_byte_count;
    logic       v4_nopayload_byte_count;
    logic       v4_header_bad_byte_count;
    logic       v4_good_byte_count;
    logic [1:0] rsvd_mid;
    logic       icmp_bad_frame_count;
    logic       icmp_good_frame_count;
    logic       tcp_bad_frame_count;
    logic       tcp_good_frame_count;
    logic       udp_bad_frame_count;
    logic       udp_good_frame_count;
    logic       v6_nopayload_frame_count;
    logic       v6_header_bad_frame_count;
    logic       v6_good_frame_count;
    logic       v4_udp_nocsum_frame_count;
    logic       v4_fragment_frame_count;
    logic       v4_nopayload_frame_count;
    logic       v4_header_bad_frame_count;
    logic       v4_good_frame_count;
  } counter_bits_t;

  // expands wishbone byte selects to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

endpackage

// *** hdl/wb_word_slave.sv ***
// classic wishbone slave front end: one-wait-state ack and read capture
`timescale 1ns/1ps
module wb_word_slave (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire rx_csum_pkg::wb_req_t req,
  input  wire logic [31:0]         rdata,
  output logic                     ack,
  output logic [31:0]              dat_o,
  output logic                     wr_stb
);
  import rx_csum_pkg::*;

  wire req_new = req.cyc & req.stb & ~ack;

  // write lands on the edge where the master samples ack
  assign wr_stb = ack & req.cyc & req.stb & req.we;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack   <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack <= req_new;
      if (req_new) begin
        dat_o <= req.we ? 32'h0000_0000 : rdata;
      end
    end
  end

endmodule // wb_word_slave

// *** hdl/sticky_w1c.sv ***
// sticky event bits, write one to clear, a new event wins over the clear
`timescale 1ns/1ps
module sticky_w1c (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [31:0] set,
  input  wire logic [31:0] clr,
  output logic [31:0]      q
);
  import rx_csum_pkg::*;
  `include "rx_csum_map.svh"

  wire [31:0] next_q = ((q & ~clr) | set) & `RCM_VALID;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= `RCM_STATUS_RST;
    end else begin
      q <= next_q;
    end
  end

endmodule // sticky_w1c

// *** bench/rx_checksum_counter_irq_mask_bench.sv ***
// self-checking bench for the receive checksum counter mask block
`timescale 1ns/1ps
`include "rx_csum_map.svh"
module rx_checksum_counter_irq_mask_bench;
  logic        clk_sys;
  logic        rst_n;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [31:0] counter_half;
  logic [31:0] counter_max;
  logic        irq;
  int          n_mismatch;
  int          compares;
  logic [31:0] seed;
  logic [31:0] mask_m;
  logic [31:0] stat_m;
  logic [31:0] r;
  logic [11:0] bad_adr [3] = '{12'h204, 12'h000, 12'hffc};

  rx_checksum_counter_irq_mask rx_checksum_counter_irq_mask_i (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .wb_cyc_i     (wb_cyc_i),
    .wb_stb_i     (wb_stb_i),
    .wb_we_i      (wb_we_i),
    .wb_adr_i     (wb_adr_i),
    .wb_sel_i     (wb_sel_i),
    .wb_dat_i     (wb_dat_i),
    .wb_dat_o     (wb_dat_o),
    .wb_ack_o     (wb_ack_o),
    .counter_half (counter_half),
    .counter_max  (counter_max),
    .irq          (irq)
  );

  always #5 clk_sys = ~clk_sys;

  // -----------------------------------------------------------------
  // expectation helpers
  // -----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] lanes(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic [31:0] reg_exp(input logic [11:0] adr);
    if (adr[11:2] == `RCM_MASK_OFF >> 2) return mask_m;
    if (adr[11:2] == `RCM_STATUS_OFF >> 2) return stat_m;
    return 32'h0000_0000;
  endfunction

  // -----------------------------------------------------------------
  // checks and bus cycles
  // -----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check_irq();
    @(negedge clk_sys);
    check("irq", {31'h0, irq}, {31'h0, |(stat_m & ~mask_m)});
  endtask

  task automatic wb_xfer(input logic we, input logic [11:0] adr,
                         input logic [3:0] sel, input logic [31:0] dat,
                         output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    n = 0;
    // ack and read data are taken at the edge where ack is seen high
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    check("ack", {31'h0, wb_ack_o}, 32'h0000_0001);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] adr, input logic [3:0] sel,
                    input logic [31:0] dat);
    logic [31:0] q;
    wb_xfer(1'b1, adr, sel, dat, q);
    if (adr == `RCM_MASK_OFF)
      mask_m = (mask_m & ~lanes(sel)) | (dat & lanes(sel) & `RCM_VALID);
    if (adr == `RCM_STATUS_OFF)
      stat_m = (stat_m & ~(dat & lanes(sel)))
               | ((counter_half | counter_max) & `RCM_VALID);
    check_irq();
  endtask

  task automatic rd_chk(input logic [11:0] adr);
    logic [31:0] q;
    wb_xfer(1'b0, adr, 4'hf, 32'h0000_0000, q);
    check("read data", q, reg_exp(adr));
  endtask

  task automatic pulse(input logic [31:0] h, input logic [31:0] m);
    @(posedge clk_sys);
    counter_half <= h;
    counter_max  <= m;
    @(posedge clk_sys);
    counter_half <= 32'h0000_0000;
    counter_max  <= 32'h0000_0000;
    stat_m = stat_m | ((h | m) & `RCM_VALID);
    check_irq();
  endtask

  task wrap_up();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #300_000;
    n_mismatch++;
    wrap_up();
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
    wb_adr_i = 12'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    counter_half = 32'h0000_0000;
    counter_max = 32'h0000_0000;
    n_mismatch = 0;
    compares = 0;
    seed = 32'h24bd;
    mask_m = `RCM_MASK_RST;
    stat_m = `RCM_STATUS_RST;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(`RCM_MASK_OFF);
    rd_chk(`RCM_STATUS_OFF);
    check_irq();
    for (int i = 0; i < 32; i++) begin
      wr(`RCM_MASK_OFF, 4'hf, 32'h1 << i);
      rd_chk(`RCM_MASK_OFF);
    end
    repeat (12) begin
      wr(`RCM_MASK_OFF, rnd() & 4'hf, rnd());
      rd_chk(`RCM_MASK_OFF);
    end
    foreach (bad_adr[k]) begin
      wr(bad_adr[k], 4'hf, 32'hffff_ffff);
      rd_chk(bad_adr[k]);
      rd_chk(`RCM_MASK_OFF);
    end
    // every counter raises its bit, even bits by half and odd bits by full crossing
    wr(`RCM_MASK_OFF, 4'hf, 32'h0000_0000);
    for (int i = 0; i < 32; i++) begin
      if (i % 2 == 0) pulse(32'h1 << i, 32'h0);
      else pulse(32'h0, 32'h1 << i);
      rd_chk(`RCM_STATUS_OFF);
      wr(`RCM_STATUS_OFF, 4'hf, 32'h1 << i);
    end
    // all masked: status still records, irq stays low
    wr(`RCM_MASK_OFF, 4'hf, 32'hffff_ffff);
    pulse(rnd(), rnd());
    rd_chk(`RCM_STATUS_OFF);
    repeat (6) wr(`RCM_MASK_OFF, rnd() & 4'hf, rnd());
    wr(`RCM_STATUS_OFF, 4'hf, 32'hffff_ffff);
    repeat (60) begin
      r = rnd();
      case (r[1:0])
        2'd0: wr(`RCM_MASK_OFF, rnd() & 4'hf, rnd());
        2'd1: wr(`RCM_STATUS_OFF, rnd() & 4'hf, rnd());
        default: pulse(rnd() & rnd(), rnd() & rnd());
      endcase
      rd_chk(`RCM_MASK_OFF);
      rd_chk(`RCM_STATUS_OFF);
    end
    // a crossing held across its own clear keeps the bit set
    @(posedge clk_sys);
    counter_max <= 32'h0101_0101;
    stat_m = stat_m | (32'h0101_0101 & `RCM_VALID);
    wr(`RCM_STATUS_OFF, 4'hf, 32'hffff_ffff);
    @(posedge clk_sys);
    counter_max <= 32'h0000_0000;
    rd_chk(`RCM_STATUS_OFF);
    // reset in mid-run clears everything
    wr(`RCM_MASK_OFF, 4'hf, 32'h1234_5678);
    pulse(32'h0000_00ff, 32'h0000_0000);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    mask_m = `RCM_MASK_RST;
    stat_m = `RCM_STATUS_RST;
    check_irq();
    rd_chk(`RCM_MASK_OFF);
    rd_chk(`RCM_STATUS_OFF);
    wrap_up();
  end
endmodule // rx_checksum_counter_irq_mask_bench
